// >>> hdl/bafo_core.sv
// execution datapath: add with file, and with file or literal, bit clear, direction load
`timescale 1ns/1ps
module bafo_core
  import bafo_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  // instruction taken at the end of each instruction cycle
  input  wire logic [INSN_W-1:0] insn,
  input  wire logic              insn_valid,
  input  wire logic              prescaler_on_timer,
  // file register space outside this block
  input  wire logic [7:0]        file_rdata,
  output logic [4:0]             file_addr,
  output logic [7:0]             file_wdata,
  output logic                   file_we,
  // port pins
  input  wire logic [7:0]        pin_in,
  output logic [7:0]             pin_out,
  output logic [7:0]             pin_oe,
  // core state
  output logic [7:0]             acc,
  output logic [7:0]             status,
  output logic                   pc_bit8_clr,
  output logic                   prescaler_clr,
  output logic                   cycle_end
);
  bafo_dec_if dif ();
  bafo_decode u_dec (.insn(insn), .dec(dif));

  logic [1:0] phase_r;
  logic [7:0] pin_s1_r, pin_s2_r;
  logic [7:0] acc_r, status_r, port_r, dir_r;
  logic [4:0] faddr_r;
  logic [7:0] wdata_r;
  logic       we_r, pc8_r, psc_r, end_r;

  // four oscillator phases per instruction cycle; execute on the last
  wire last_ph = (phase_r == PHASE_LAST); // see RULE11
  wire exec    = last_ph && insn_valid;

  // port reads use synchronised pin levels, never the output latch
  wire [7:0] fval = (dif.faddr == ADDR_PORT) ? pin_s2_r : file_rdata; // see RULE2

  wire [8:0] sum     = {1'b0, acc_r} + {1'b0, fval}; // see RULE6
  wire [4:0] lo_sum  = {1'b0, acc_r[3:0]} + {1'b0, fval[3:0]};
  wire [7:0] and_f   = acc_r & fval; // see RULE10
  wire [7:0] and_l   = acc_r & dif.lit; // see RULE9
  wire [7:0] bmask   = ~(8'h01 << dif.bsel);
  wire [7:0] bcf_res = fval & bmask; // see RULE8

  wire       is_file = (dif.op == BAFO_ADD_FILE) || (dif.op == BAFO_AND_FILE);
  wire [7:0] res     = (dif.op == BAFO_ADD_FILE) ? sum[7:0] :
                       (dif.op == BAFO_AND_FILE) ? and_f :
                       (dif.op == BAFO_CLR_BIT)  ? bcf_res : and_l;
  wire       to_file = (is_file && dif.dest) || (dif.op == BAFO_CLR_BIT); // see RULE7
  wire       to_acc  = (is_file && !dif.dest) || (dif.op == BAFO_AND_LIT);
  wire       zset    = is_file || (dif.op == BAFO_AND_LIT);
  wire       wr_file = exec && to_file;
  wire       st_wr   = wr_file && (dif.faddr == ADDR_STATUS);

  // a write to status by the instruction itself wins over its flag update
  logic [7:0] status_nxt;
  always_comb begin
    status_nxt = st_wr ? res : status_r;
    if (exec && zset && !st_wr) begin
      status_nxt[FLAG_Z] = (res == 8'h00);
    end
    if (exec && dif.op == BAFO_ADD_FILE && !st_wr) begin
      status_nxt[FLAG_C]  = sum[8];
      status_nxt[FLAG_DC] = lo_sum[4];
    end
  end

  // pins move at any time, so only the second flop feeds the port read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r  <= 2'h0;
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end else if (clk_en) begin
      phase_r  <= phase_r + 2'h1;
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_r    <= ACC_RESET;
      status_r <= STATUS_RESET;
      port_r   <= PORT_RESET;
      dir_r    <= DIR_RESET;
    end else if (clk_en) begin
      status_r <= status_nxt;
      if (exec && to_acc) begin
        acc_r <= res;
      end
      if (wr_file && dif.faddr == ADDR_PORT) begin
        port_r <= res;
      end
      if (exec && dif.op == BAFO_DIR_LOAD) begin
        dir_r <= acc_r; // see RULE3
      end
    end
  end

  // file strobes leave one clock after the execute edge, so the file side
  // sees registered address and data rather than the decode path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      faddr_r <= 5'h00;
      wdata_r <= 8'h00;
      we_r    <= 1'b0;
      pc8_r   <= 1'b0;
      psc_r   <= 1'b0;
      end_r   <= 1'b0;
    end else if (clk_en) begin
      faddr_r <= dif.faddr;
      wdata_r <= res;
      we_r    <= wr_file;
      // any write of the pc low byte from this subset is a non-branch pc write
      pc8_r   <= wr_file && (dif.faddr == ADDR_PCL); // see RULE1
      psc_r   <= wr_file && (dif.faddr == ADDR_TIMER) && prescaler_on_timer; // see RULE5
      end_r   <= last_ph;
    end
  end

  assign file_addr     = faddr_r;
  assign file_wdata    = wdata_r;
  assign file_we       = we_r;
  assign pin_out       = port_r;
  // a one in a direction bit turns the driver off
  assign pin_oe        = ~dir_r; // see RULE4
  assign acc           = acc_r;
  assign status        = status_r;
  assign pc_bit8_clr   = pc8_r;
  assign prescaler_clr = psc_r;
  assign cycle_end     = end_r;

  a_cycle_four: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE11
    (clk_en && last_ph) |=> (!last_ph || !clk_en));
  a_add_carry: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE6
    (clk_en && exec && dif.op == BAFO_ADD_FILE && !st_wr) |=> status_r[FLAG_C] == $past(sum[8]));
  a_and_zero: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE9
    (clk_en && exec && dif.op == BAFO_AND_LIT) |=> (acc_r == $past(and_l))
      && status_r[FLAG_Z] == (acc_r == 8'h00));
  a_andf_dest: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE10
    (clk_en && exec && dif.op == BAFO_AND_FILE && dif.dest) |=> file_we
      && file_wdata == $past(and_f) && $stable(acc_r));
  a_dest_acc: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE7
    (clk_en && exec && is_file && !dif.dest) |=> !file_we);
  a_bcf_flags: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE8
    (clk_en && exec && dif.op == BAFO_CLR_BIT && dif.faddr != ADDR_STATUS)
      |=> $stable(status_r) && file_we && (file_wdata & ~$past(bmask)) == 8'h00);
  a_dir_load: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE3
    (clk_en && exec && dif.op == BAFO_DIR_LOAD) |=> pin_oe == ~$past(acc_r));
  a_psc_clear: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE5
    (clk_en && wr_file && dif.faddr == ADDR_TIMER && prescaler_on_timer) |=> prescaler_clr);
  a_pc_bit8: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE1
    (clk_en && wr_file && dif.faddr == ADDR_PCL) |=> pc_bit8_clr);
  a_port_pins: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE2
    (clk_en && exec && is_file && dif.dest && dif.faddr == ADDR_PORT
      && dif.op == BAFO_AND_FILE) |=> pin_out == $past(acc_r & pin_s2_r));

  // execute-path checks; expectations are rebuilt from operands, not from res
  a_phase_step: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE11
    clk_en
      |=> (phase_r == 2'($past(phase_r) + 2'h1)));
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE11
    !clk_en
      |=> ($stable(acc_r) && $stable(status_r) && $stable(phase_r) && $stable(dir_r)));
  a_end_pulse: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE11
    (clk_en && cycle_end)
      |=> !cycle_end);
  a_invalid_idle: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE11
    (clk_en && last_ph && !insn_valid)
      |=> ($stable(acc_r) && $stable(status_r) && !file_we));
  a_add_dcarry: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE6
    (clk_en && exec && dif.op == BAFO_ADD_FILE && !st_wr)
      |=> (status_r[FLAG_DC] == ((5'($past(acc_r[3:0])) + 5'($past(fval[3:0]))) > 5'h0F))
      && (status_r[FLAG_Z] == (8'($past(acc_r) + $past(fval)) == 8'h00)));
  a_add_route: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE7
    (clk_en && exec && dif.op == BAFO_ADD_FILE && !dif.dest)
      |=> (acc_r == 8'($past(acc_r) + $past(fval))) && !file_we);
  a_andf_flags: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE10
    (clk_en && exec && dif.op == BAFO_AND_FILE && !st_wr)
      |=> (status_r[FLAG_Z] == (($past(acc_r) & $past(fval)) == 8'h00))
      && (status_r[FLAG_DC:FLAG_C] == $past(status_r[FLAG_DC:FLAG_C])));
  a_andf_route: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE10
    (clk_en && exec && dif.op == BAFO_AND_FILE && !dif.dest)
      |=> (acc_r == ($past(acc_r) & $past(fval))) && !file_we);
  a_andl_flags: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE9
    (clk_en && exec && dif.op == BAFO_AND_LIT)
      |=> (status_r[FLAG_DC:FLAG_C] == $past(status_r[FLAG_DC:FLAG_C])) && !file_we);
  a_dir_ignore: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE3
    (clk_en && exec && insn[11:3] == OP_DIR_LOAD && insn[2:0] < DIR_PORT_LO)
      |=> $stable(pin_oe));
  a_psc_dest0: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE5
    (clk_en && exec && is_file && !dif.dest && dif.faddr == ADDR_TIMER)
      |=> !prescaler_clr);
  a_psc_unowned: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE5
    (clk_en && !prescaler_on_timer)
      |=> !prescaler_clr);
  a_pc_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE1
    (clk_en && !(exec && dif.faddr == ADDR_PCL))
      |=> !pc_bit8_clr);
  a_port_bclr: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE2
    (clk_en && exec && dif.op == BAFO_CLR_BIT && dif.faddr == ADDR_PORT)
      |=> (pin_out == ($past(pin_s2_r) & ~(8'h01 << $past(dif.bsel)))));
  a_bcf_keep: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE8
    (clk_en && exec && dif.op == BAFO_CLR_BIT)
      |=> ((file_wdata | (8'h01 << $past(dif.bsel)))
        == ($past(fval) | (8'h01 << $past(dif.bsel))))
      && (file_addr == $past(dif.faddr)));
  a_we_pulse: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE7
    (clk_en && file_we)
      |=> !file_we);
  a_file_addr: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE7
    (clk_en && wr_file)
      |=> (file_addr == $past(dif.faddr)) && file_we);
endmodule : bafo_core

// >>> shared/bafo_pkg.sv
// constants and types for the byte alu file-ops execution block
// Overview of operation
// RULE1: non-branch pc writes force pc bit eight low
// RULE2: port read-modify-write uses sampled pin levels
// RULE3: load_direction_latches with f 5..7 copies accumulator
// RULE4: direction bit one tristates pin, zero drives
// RULE5: writing timer register clears assigned prescaler
// RULE6: add_acc_file adds, updates carry, digit carry, zero
// RULE7: destination bit zero accumulator, one file register
// RULE8: clear_file_bit clears one bit, flags untouched
// RULE9: and_acc_literal ands literal, zero flag only
// RULE10: and_acc_file ands file, routes by destination
// RULE11: instruction cycle spans four oscillator periods
package bafo_pkg;
  localparam int          INSN_W        = 12;
  localparam int          PHASES        = 4;
  localparam logic [1:0]  PHASE_LAST    = 2'h3;
  localparam logic [4:0]  ADDR_TIMER    = 5'h01;
  localparam logic [4:0]  ADDR_PCL      = 5'h02;
  localparam logic [4:0]  ADDR_STATUS   = 5'h03;
  localparam logic [4:0]  ADDR_PORT     = 5'h06;
  localparam logic [2:0]  DIR_PORT_LO   = 3'h5;
  localparam logic [2:0]  DIR_PORT_HI   = 3'h7;
  localparam logic [7:0]  DIR_RESET     = 8'hFF;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [7:0]  PORT_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h18;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_DC       = 1;
  localparam int          FLAG_Z        = 2;
  localparam logic [5:0]  OP_ADD_FILE   = 6'h07;
  localparam logic [5:0]  OP_AND_FILE   = 6'h05;
  localparam logic [3:0]  OP_CLR_BIT    = 4'h4;
  localparam logic [3:0]  OP_AND_LIT    = 4'hE;
  localparam logic [8:0]  OP_DIR_LOAD   = 9'h000;
  typedef enum logic [2:0] {
    BAFO_NONE, BAFO_ADD_FILE, BAFO_AND_FILE, BAFO_CLR_BIT, BAFO_AND_LIT, BAFO_DIR_LOAD
  } bafo_op_t;
endpackage : bafo_pkg

// >>> shared/bafo_dec_if.sv
// decoded instruction fields passed from decoder to datapath
`timescale 1ns/1ps
interface bafo_dec_if;
  import bafo_pkg::*;
  bafo_op_t   op;
  logic [4:0] faddr;
  logic       dest;
  logic [2:0] bsel;
  logic [7:0] lit;
  modport dec (output op, faddr, dest, bsel, lit);
  modport use_side (input op, faddr, dest, bsel, lit);
endinterface : bafo_dec_if

// >>> hdl/bafo_decode.sv
// instruction field decoder for the supported subset
`timescale 1ns/1ps
module bafo_decode
  import bafo_pkg::*;
(
  // instruction word
  input  wire logic [INSN_W-1:0] insn,
  // decoded fields
  bafo_dec_if.dec                dec
);
  wire is_add = (insn[11:6] == OP_ADD_FILE);
  wire is_and = (insn[11:6] == OP_AND_FILE);
  wire is_bcf = (insn[11:8] == OP_CLR_BIT);
  wire is_anl = (insn[11:8] == OP_AND_LIT);
  wire is_dir = (insn[11:3] == OP_DIR_LOAD) && (insn[2:0] >= DIR_PORT_LO)
                && (insn[2:0] <= DIR_PORT_HI); // see RULE3
  assign dec.op = is_add ? BAFO_ADD_FILE : is_and ? BAFO_AND_FILE : is_bcf ? BAFO_CLR_BIT :
                  is_anl ? BAFO_AND_LIT : is_dir ? BAFO_DIR_LOAD : BAFO_NONE;
  assign dec.faddr = insn[4:0];
  assign dec.dest  = insn[5];
  assign dec.bsel  = insn[7:5];
  assign dec.lit   = insn[7:0];
endmodule : bafo_decode

// >>> dv/tb_byte_alu_file_ops.sv
// self-checking bench for the byte alu file-ops execution datapath
`timescale 1ns/1ps
module tb_byte_alu_file_ops;
  import bafo_pkg::*;
  // f holds the expected {file_we, prescaler_clr, pc_bit8_clr}
  typedef struct {logic [11:0] i; logic [7:0] rd, acc, st, wd; logic [2:0] f;} bafo_row_t;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic        insn_valid = 1'b1;
  logic        prescaler_on_timer = 1'b1;
  logic [11:0] insn = 12'h000;
  logic [7:0]  file_rdata = 8'h00;
  // pins stay fixed, so the two-flop synchroniser has long settled before any execute edge
  logic [7:0]  pin_in = 8'hF3;
  logic [4:0]  file_addr;
  logic [7:0]  file_wdata, pin_out, pin_oe, acc, status;
  logic        file_we, pc_bit8_clr, prescaler_clr, cycle_end;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;
  bafo_row_t   rows[15] = '{
    '{12'h1D0, 8'h17, 8'h17, 8'h18, 8'h00, 3'h0}, '{12'h1F1, 8'hC2, 8'h17, 8'h18, 8'hD9, 3'h4},
    '{12'h1D2, 8'hE9, 8'h00, 8'h1F, 8'h00, 3'h0}, '{12'hE5F, 8'h00, 8'h00, 8'h1F, 8'h00, 3'h0},
    '{12'h1D3, 8'h5A, 8'h5A, 8'h18, 8'h00, 3'h0}, '{12'hE0F, 8'h00, 8'h0A, 8'h18, 8'h00, 3'h0},
    '{12'h174, 8'hF0, 8'h0A, 8'h1C, 8'h00, 3'h4}, '{12'h155, 8'h0E, 8'h0A, 8'h18, 8'h00, 3'h0},
    '{12'h4F6, 8'hC7, 8'h0A, 8'h18, 8'h47, 3'h4}, '{12'h41F, 8'hFF, 8'h0A, 8'h18, 8'hFE, 3'h4},
    '{12'h1E1, 8'h33, 8'h0A, 8'h18, 8'h3D, 3'h6}, '{12'h1C1, 8'h01, 8'h0B, 8'h18, 8'h00, 3'h0},
    '{12'h402, 8'h81, 8'h0B, 8'h18, 8'h80, 3'h5}, '{12'h426, 8'h00, 8'h0B, 8'h18, 8'hF1, 3'h4},
    '{12'h166, 8'h00, 8'h0B, 8'h18, 8'h03, 3'h4}};

  bafo_core dut_u (.core_clk, .nrst, .clk_en, .insn, .insn_valid, .prescaler_on_timer,
    .file_rdata, .file_addr, .file_wdata, .file_we, .pin_in, .pin_out, .pin_oe, .acc,
    .status, .pc_bit8_clr, .prescaler_clr, .cycle_end);

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // present one instruction, then wait a bounded time for its completion pulse
  task automatic run(input logic [11:0] i, input logic [7:0] rd);
    @(posedge core_clk);
    insn <= i;
    file_rdata <= rd;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (cycle_end !== 1'b1 && n < 8);
    if (n >= 8) begin
      bad_count++;
      final_report();
    end
  endtask : run

  task automatic rst_chk;
    chk("rst acc", ACC_RESET, acc);
    chk("rst status", STATUS_RESET, status);
    chk("rst oe", ~DIR_RESET, pin_oe);
    chk("rst out", PORT_RESET, pin_out);
  endtask : rst_chk

  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_chk();
    @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[k]) begin
      run(rows[k].i, rows[k].rd);
      if (k > 0) chk("spacing", 8'h03, 8'(n));
      chk("acc", rows[k].acc, acc);
      chk("status", rows[k].st, status);
      chk("we", {7'h00, rows[k].f[2]}, {7'h00, file_we});
      if (rows[k].f[2]) chk("wdata", rows[k].wd, file_wdata);
      chk("presc", {7'h00, rows[k].f[1]}, {7'h00, prescaler_clr});
      chk("pcclr", {7'h00, rows[k].f[0]}, {7'h00, pc_bit8_clr});
    end
    // last row ands acc with the pins (f6), not with the output latch or file data
    chk("pin out", 8'h03, pin_out);
    // operand 4 lies outside the accepted range and must leave the latches alone
    for (int f = 4; f < 8; f++) begin
      run({9'h000, 3'(f)}, 8'h00);
      chk("oe", (f > 4) ? 8'hF4 : 8'h00, pin_oe);
    end
    @(posedge core_clk);
    prescaler_on_timer <= 1'b0;
    run(12'h1E1, 8'h00);
    chk("presc off", 8'h00, {7'h00, prescaler_clr});
    // an and-literal with zero offered while not valid must not clear acc
    @(posedge core_clk);
    insn_valid <= 1'b0;
    run(12'hE00, 8'h00);
    chk("idle acc", 8'h0B, acc);
    chk("idle we", 8'h00, {7'h00, file_we});
    // the same and-literal stays pending, valid, while the enable is low
    @(posedge core_clk);
    insn_valid <= 1'b1;
    clk_en <= 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    chk("frozen acc", 8'h0B, acc);
    chk("frozen status", 8'h18, status);
    @(posedge core_clk);
    clk_en <= 1'b1;
    run(12'h1D0, 8'h01);
    chk("resume acc", 8'h0C, acc);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    #1;
    rst_chk();
    // after a mid-run reset the first execute is again the fourth enabled edge
    @(posedge core_clk);
    nrst <= 1'b1;
    run(12'h1D0, 8'h05);
    chk("rst spacing", 8'h03, 8'(n));
    chk("rst add", 8'h05, acc);
    final_report();
  end
endmodule : tb_byte_alu_file_ops
